// ---- rtl/uart_irq_pkg.sv ----
// constants for the serial interrupt and infrared shaping block
package uart_irq_pkg;
	localparam logic [15:0] ADDR_STATUS  = 16'h4100;
	localparam logic [15:0] ADDR_TXDATA  = 16'h4101;
	localparam logic [15:0] ADDR_RXDATA  = 16'h4102;
	localparam logic [15:0] ADDR_FORMAT  = 16'h4103;
	localparam logic [15:0] ADDR_CONTROL = 16'h4104;
	localparam logic [15:0] ADDR_EXPAND  = 16'h4105;
	localparam int ST_TXEMPTY  = 0;
	localparam int ST_RXREADY  = 1;
	localparam int ST_TXBUSY   = 2;
	localparam int ST_RXTWO    = 3;
	localparam int ST_OVRERR   = 4;
	localparam int ST_PARERR   = 5;
	localparam int ST_FRMERR   = 6;
	localparam int CTL_THR     = 1;
	localparam int CTL_TXE_IEN = 4;
	localparam int CTL_RXF_IEN = 5;
	localparam int CTL_RXE_IEN = 6;
	localparam int EXP_IR_MODE = 0;
	localparam int EXP_CLK_LO = 4;
	localparam logic [7:0] FORMAT_WMASK  = 8'h1F;
	localparam logic [7:0] CONTROL_WMASK = 8'h7F;
	localparam logic [7:0] EXPAND_WMASK  = 8'h71;
	localparam logic [7:0] FORMAT_RST    = 8'h00;
	localparam logic [7:0] CONTROL_RST   = 8'h00;
	localparam logic [7:0] EXPAND_RST    = 8'h00;
	localparam logic [7:0] TXDATA_RST    = 8'h00;
	localparam logic [3:0] IR_BIT_TICKS_M1 = 4'hF;
	localparam logic [3:0] IR_TX_LOW_TICKS = 4'h3;
	localparam logic [4:0] IR_RX_STRETCH   = 5'h10;
	localparam logic [1:0] IR_VALID_SAMPLES = 2'h3;
endpackage : uart_irq_pkg

// ---- rtl/uart_irq_irda_modem.sv ----
// serial port status, interrupt request and infrared pulse shaping
`timescale 1ns/100ps
module uart_irq_irda_modem (
	input  wire logic        core_clk_i,
	input  wire logic        srst_i,
	input  wire logic [15:0] addr_i,
	input  wire logic [7:0]  wdata_i,
	input  wire logic        wr_i,
	input  wire logic        rd_i,
	input  wire logic        tx_load_i,
	input  wire logic        tx_busy_i,
	input  wire logic        rx_load_i,
	input  wire logic [7:0]  rx_byte_i,
	input  wire logic        rx_parity_err_i,
	input  wire logic        rx_frame_err_i,
	input  wire logic        sclk_tick_i,
	input  wire logic        tx_shift_i,
	input  wire logic        rx_pin_i,
	output logic      [7:0]  rdata_o,
	output logic             irq_o,
	output logic      [7:0]  tx_data_o,
	output logic      [7:0]  format_o,
	output logic      [7:0]  control_o,
	output logic             serial_out_pin_o,
	output logic             rx_to_shift_o
);

	function automatic logic hit(input logic [15:0] a, input logic [15:0] o);
		return a == o;
	endfunction : hit

	// detection tick: prescaler low n bits all ones
	function automatic logic det_tick_f(input logic [6:0] p,
					    input logic [2:0] n);
		logic [6:0] m;
		m = 7'((8'h01 << n) - 8'h01);
		return &(p | ~m);
	endfunction : det_tick_f

	logic [7:0] ctl_r, ctl_nxt, fmt_r, fmt_nxt, exp_r, exp_nxt;
	logic [7:0] txd_r, txd_nxt, buf0_r, buf0_nxt, buf1_r, buf1_nxt;
	logic [1:0] cnt_r, cnt_nxt;
	logic       txe_flag_r, txe_flag_nxt, ovr_flag_r, ovr_flag_nxt;
	logic       par_flag_r, par_flag_nxt, frm_flag_r, frm_flag_nxt, irq_nxt;
	logic [7:0] rdata_nxt;
	logic       pop, push, ovr, rx_ready_rise, rx_two_rise, err_ev, clr_wr;

	always_comb begin
		ctl_nxt   = ctl_r;
		fmt_nxt   = fmt_r;
		exp_nxt   = exp_r;
		txd_nxt   = txd_r;
		buf0_nxt  = buf0_r;
		buf1_nxt  = buf1_r;
		cnt_nxt   = cnt_r;
		rdata_nxt = 8'h00;
		clr_wr    = wr_i && hit(addr_i, uart_irq_pkg::ADDR_STATUS);
		pop       = rd_i && hit(addr_i, uart_irq_pkg::ADDR_RXDATA)
			    && (cnt_r != 2'h0);
		ovr       = rx_load_i && (cnt_r == 2'h2) && !pop;
		push      = rx_load_i && !ovr;
		if (wr_i) begin
			if (hit(addr_i, uart_irq_pkg::ADDR_TXDATA))
				txd_nxt = wdata_i;
			if (hit(addr_i, uart_irq_pkg::ADDR_FORMAT))
				fmt_nxt = wdata_i & uart_irq_pkg::FORMAT_WMASK;
			if (hit(addr_i, uart_irq_pkg::ADDR_CONTROL))
				ctl_nxt = wdata_i & uart_irq_pkg::CONTROL_WMASK;
			if (hit(addr_i, uart_irq_pkg::ADDR_EXPAND))
				exp_nxt = wdata_i & uart_irq_pkg::EXPAND_WMASK;
		end
		// two-entry receive buffer, oldest in buf0
		if (pop && push) begin
			if (cnt_r == 2'h1) begin
				buf0_nxt = rx_byte_i;
			end else begin
				buf0_nxt = buf1_r;
				buf1_nxt = rx_byte_i;
			end
		end else if (pop) begin
			buf0_nxt = buf1_r;
			cnt_nxt  = cnt_r - 2'h1;
		end else if (push) begin
			if (cnt_r == 2'h0)
				buf0_nxt = rx_byte_i;
			else
				buf1_nxt = rx_byte_i;
			cnt_nxt = cnt_r + 2'h1;
		end
		rx_ready_rise = (cnt_r == 2'h0) && (cnt_nxt != 2'h0);
		rx_two_rise   = (cnt_r != 2'h2) && (cnt_nxt == 2'h2);
		// set wins over clear: write-one for error flags, any TXDATA write for the empty flag
		txe_flag_nxt = tx_load_i || (txe_flag_r && !(wr_i
			&& hit(addr_i, uart_irq_pkg::ADDR_TXDATA)));
		par_flag_nxt = (rx_load_i && rx_parity_err_i)
			|| (par_flag_r && !(clr_wr
			&& wdata_i[uart_irq_pkg::ST_PARERR]));
		frm_flag_nxt = (rx_load_i && rx_frame_err_i)
			|| (frm_flag_r && !(clr_wr
			&& wdata_i[uart_irq_pkg::ST_FRMERR]));
		ovr_flag_nxt = ovr || (ovr_flag_r && !(clr_wr
			&& wdata_i[uart_irq_pkg::ST_OVRERR]));
		err_ev = (rx_load_i && (rx_parity_err_i || rx_frame_err_i))
			 || ovr;
		// single request line, no mode term in it
		irq_nxt = (ctl_r[uart_irq_pkg::CTL_TXE_IEN] && tx_load_i)
			  || (ctl_r[uart_irq_pkg::CTL_RXF_IEN]
			  && (ctl_r[uart_irq_pkg::CTL_THR] ? rx_two_rise
			  : rx_ready_rise))
			  || (ctl_r[uart_irq_pkg::CTL_RXE_IEN]
			  && err_ev);
		if (rd_i) begin
			unique case (addr_i)
			uart_irq_pkg::ADDR_STATUS:
				rdata_nxt = {1'b0, frm_flag_r, par_flag_r,
					     ovr_flag_r, cnt_r == 2'h2, tx_busy_i,
					     cnt_r != 2'h0, txe_flag_r};
			uart_irq_pkg::ADDR_TXDATA:  rdata_nxt = txd_r;
			uart_irq_pkg::ADDR_RXDATA:
				rdata_nxt = (cnt_r != 2'h0) ? buf0_r : 8'h00;
			uart_irq_pkg::ADDR_FORMAT:  rdata_nxt = fmt_r;
			uart_irq_pkg::ADDR_CONTROL: rdata_nxt = ctl_r;
			uart_irq_pkg::ADDR_EXPAND:  rdata_nxt = exp_r;
			default:                    rdata_nxt = 8'h00;
			endcase
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			ctl_r   <= uart_irq_pkg::CONTROL_RST;
			fmt_r   <= uart_irq_pkg::FORMAT_RST;
			exp_r   <= uart_irq_pkg::EXPAND_RST;
			txd_r   <= uart_irq_pkg::TXDATA_RST;
			buf0_r  <= 8'h00;
			buf1_r  <= 8'h00;
			cnt_r   <= 2'h0;
			txe_flag_r <= 1'b1;
			ovr_flag_r <= 1'b0;
			par_flag_r <= 1'b0;
			frm_flag_r <= 1'b0;
			irq_o   <= 1'b0;
			rdata_o <= 8'h00;
		end else begin
			ctl_r   <= ctl_nxt;
			fmt_r   <= fmt_nxt;
			exp_r   <= exp_nxt;
			txd_r   <= txd_nxt;
			buf0_r  <= buf0_nxt;
			buf1_r  <= buf1_nxt;
			cnt_r   <= cnt_nxt;
			txe_flag_r <= txe_flag_nxt;
			ovr_flag_r <= ovr_flag_nxt;
			par_flag_r <= par_flag_nxt;
			frm_flag_r <= frm_flag_nxt;
			irq_o   <= irq_nxt;
			rdata_o <= rdata_nxt;
		end
	end

	assign tx_data_o = txd_r;
	assign format_o  = fmt_r;
	assign control_o = ctl_r;

	// infrared shaping
	logic       ir_on;
	logic [2:0] det_sel;
	logic [6:0] presc_r, presc_nxt;
	logic       txprev_r, txprev_nxt, serial_out_pin_nxt, rxs_nxt, det_tick;
	logic [3:0] txcnt_r, txcnt_nxt;
	logic [1:0] lowcnt_r, lowcnt_nxt;
	logic       armed_r, armed_nxt;
	logic [4:0] str_r, str_nxt;

	always_comb begin
		ir_on      = exp_r[uart_irq_pkg::EXP_IR_MODE];
		det_sel    = exp_r[uart_irq_pkg::EXP_CLK_LO +: 3];
		presc_nxt  = presc_r + 7'h01;
		det_tick   = det_tick_f(presc_r, det_sel);
		txprev_nxt = tx_shift_i;
		txcnt_nxt  = txcnt_r;
		// restart per low bit, one bit is sixteen ticks
		if (!tx_shift_i && txprev_r)
			txcnt_nxt = 4'h0;
		else if (sclk_tick_i && !tx_shift_i)
			txcnt_nxt = (txcnt_r == uart_irq_pkg::IR_BIT_TICKS_M1)
				    ? 4'h0 : txcnt_r + 4'h1;
		serial_out_pin_nxt = ir_on ? !(!tx_shift_i
			   && txcnt_nxt < uart_irq_pkg::IR_TX_LOW_TICKS)
			   : tx_shift_i;
		lowcnt_nxt = lowcnt_r;
		armed_nxt  = armed_r;
		str_nxt    = str_r;
		if (sclk_tick_i && str_r != 5'h00)
			str_nxt = str_r - 5'h01;
		if (det_tick) begin
			if (rx_pin_i) begin
				lowcnt_nxt = 2'h0;
				armed_nxt  = 1'b1;
			end else if (lowcnt_r
				     != uart_irq_pkg::IR_VALID_SAMPLES) begin
				lowcnt_nxt = lowcnt_r + 2'h1;
			end
		end
		// third low sample means longer than two cycles
		if (armed_r && lowcnt_nxt
		    == uart_irq_pkg::IR_VALID_SAMPLES) begin
			armed_nxt = 1'b0;
			str_nxt   = uart_irq_pkg::IR_RX_STRETCH;
		end
		rxs_nxt = ir_on ? (str_nxt == 5'h00) : rx_pin_i;
	end

	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			presc_r          <= 7'h00;
			txprev_r         <= 1'b1;
			txcnt_r          <= uart_irq_pkg::IR_TX_LOW_TICKS;
			lowcnt_r         <= 2'h0;
			armed_r          <= 1'b0;
			str_r            <= 5'h00;
			serial_out_pin_o <= 1'b1;
			rx_to_shift_o    <= 1'b1;
		end else begin
			presc_r          <= presc_nxt;
			txprev_r         <= txprev_nxt;
			txcnt_r          <= txcnt_nxt;
			lowcnt_r         <= lowcnt_nxt;
			armed_r          <= armed_nxt;
			str_r            <= str_nxt;
			serial_out_pin_o <= serial_out_pin_nxt;
			rx_to_shift_o    <= rxs_nxt;
		end
	end

	default clocking a_cb @(posedge core_clk_i);
	endclocking
	default disable iff (srst_i);

	a_tx_empty_irq: assert property (
		tx_load_i && ctl_r[uart_irq_pkg::CTL_TXE_IEN]
		|=> irq_o && txe_flag_r)
		else $error("tx empty request missing");
	a_irq_all_off: assert property (
		ctl_r[6:4] == 3'h0 |=> !irq_o)
		else $error("request with all enables off");
	a_irq_has_cause: assert property (
		irq_o |-> $past(tx_load_i || rx_load_i))
		else $error("request without cause");
	a_rx_one_byte: assert property (
		!ctl_r[uart_irq_pkg::CTL_THR] && ctl_r[uart_irq_pkg::CTL_RXF_IEN]
		&& cnt_r == 2'h0 && rx_load_i |=> irq_o && cnt_r == 2'h1)
		else $error("one byte request missing");
	a_rx_two_byte: assert property (
		ctl_r[uart_irq_pkg::CTL_THR] && ctl_r[uart_irq_pkg::CTL_RXF_IEN]
		&& cnt_r == 2'h1 && rx_load_i && !pop |=> irq_o)
		else $error("two byte request missing");
	a_frame_err_irq: assert property (
		rx_load_i && rx_frame_err_i && ctl_r[uart_irq_pkg::CTL_RXE_IEN]
		|=> irq_o && frm_flag_r)
		else $error("framing error request missing");
	a_err_clear: assert property (
		frm_flag_r && clr_wr && wdata_i[uart_irq_pkg::ST_FRMERR]
		&& !(rx_load_i && rx_frame_err_i) |=> !frm_flag_r)
		else $error("framing flag not cleared");
	a_ir_stretch: assert property (
		ir_on && $rose(str_r == uart_irq_pkg::IR_RX_STRETCH)
		&& $stable(exp_r)
		|-> !rx_to_shift_o && $past(lowcnt_r) != 2'h0)
		else $error("stretch start wrong");
	a_ir_tx_pass: assert property (
		!ir_on |=> serial_out_pin_o == $past(tx_shift_i))
		else $error("normal mode output altered");

endmodule : uart_irq_irda_modem

// ---- verif/itc_model.sv ----
// behavioural interrupt controller seen by the serial request
`timescale 1ns/100ps
module irq_ctrl_model (
	input  wire logic       core_clk_i,
	input  wire logic       srst_i,
	input  wire logic       irq_i,
	input  wire logic       clr_i,
	input  wire logic       source_enable_i,
	input  wire logic       global_en_i,
	input  wire logic [2:0] level_i,
	input  wire logic [2:0] cpu_level_i,
	output logic            pending_o,
	output logic            accept_o,
	output logic [23:0]     vector_addr_o
);
	localparam logic [23:0] VECTOR_ADDR = 24'h008040;
	always_ff @(posedge core_clk_i) begin
		if (srst_i | clr_i) begin
			pending_o <= 1'b0;
		end else if (irq_i) begin
			pending_o <= 1'b1;
		end
	end
	// forward only when enabled, level above cpu
	assign accept_o = pending_o & source_enable_i & global_en_i
		& (level_i > cpu_level_i);
	assign vector_addr_o = VECTOR_ADDR;
endmodule : irq_ctrl_model

// ---- verif/tb.sv ----
// self-checking bench of the serial interrupt and infrared block
`timescale 1ns/100ps
module tb;
	logic        clk = 0, srst = 1, wr = 0, rd = 0, txl = 0, rxl = 0;
	logic        pe = 0, fe = 0, tick = 0, txs = 1, rxp = 1, src = 0;
	logic [15:0] addr = 0;
	logic [7:0]  wd = 0, rdata, b0, b1, b2;
	logic        irq, line_out, rxo, pend, acc;
	logic [7:0]  txd_q, fmt_q, ctl_q;
	int          n_errors = 0, samples_checked = 0, cyc = 0, tk = 0;
	int          ntx = 0, nrx = 0, a;
	always #2.5 clk = ~clk;
	always @(posedge clk) begin
		cyc <= cyc + 1;
		tk <= (tk + 1) % 4;
		tick <= (tk == 3);
		if (!line_out && tick) ntx <= ntx + 1;
		if (!rxo && tick) nrx <= nrx + 1;
		if (cyc > 30000) begin
			n_errors = n_errors + 1;
			close_out();
		end
	end
	uart_irq_irda_modem dut (.core_clk_i(clk), .srst_i(srst), .addr_i(addr),
		.wdata_i(wd), .wr_i(wr), .rd_i(rd), .tx_load_i(txl),
		.tx_busy_i(1'b0), .rx_load_i(rxl), .rx_byte_i(wd),
		.rx_parity_err_i(pe), .rx_frame_err_i(fe), .sclk_tick_i(tick),
		.tx_shift_i(txs), .rx_pin_i(rxp), .rdata_o(rdata), .irq_o(irq),
		.tx_data_o(txd_q), .format_o(fmt_q), .control_o(ctl_q),
		.serial_out_pin_o(line_out), .rx_to_shift_o(rxo));
	irq_ctrl_model ictl (.core_clk_i(clk), .srst_i(srst), .irq_i(irq),
		.clr_i(1'b0), .source_enable_i(src), .global_en_i(1'b1),
		.level_i(3'h5), .cpu_level_i(3'h2), .pending_o(pend),
		.accept_o(acc), .vector_addr_o());
	task chk(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED t=%0t got %h want %h", $time, got, exp);
		end
	endtask : chk
	task wr_reg(input logic [15:0] a_, input logic [7:0] d);
		@(posedge clk);
		addr <= a_; wd <= d; wr <= 1;
		@(posedge clk);
		wr <= 0;
	endtask : wr_reg
	task rd_reg(input logic [15:0] a_, input logic [7:0] exp);
		@(posedge clk);
		addr <= a_; rd <= 1;
		@(posedge clk);
		rd <= 0;
		#1 chk(rdata, exp);
	endtask : rd_reg
	// one event pulse: 0 tx, 1 rx, 2 rx parity, 3 rx frame
	task ev(input int k, input logic [7:0] d, input logic exp);
		@(posedge clk);
		wd <= d; txl <= (k == 0); rxl <= (k > 0);
		pe <= (k == 2); fe <= (k == 3);
		@(posedge clk);
		txl <= 0; rxl <= 0; pe <= 0; fe <= 0;
		#1 chk(irq, exp);
		@(posedge clk);
		#1 chk(irq, 1'b0);
	endtask : ev
	task close_out;
		$display("checks %0d mismatches %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : close_out
	initial begin
		a = $urandom(32'h3df8);
		repeat (10) @(posedge clk);
		srst <= 0;
		rd_reg(uart_irq_pkg::ADDR_STATUS, 8'h01);
		rd_reg(uart_irq_pkg::ADDR_CONTROL, 8'h00);
		rd_reg(uart_irq_pkg::ADDR_EXPAND, 8'h00);
		rd_reg(16'h4106, 8'h00);
		ev(0, 8'h00, 1'b0);
		wr_reg(uart_irq_pkg::ADDR_CONTROL, 8'h70);
		rd_reg(uart_irq_pkg::ADDR_CONTROL, 8'h70);
		chk(ctl_q, 8'h70);
		wr_reg(uart_irq_pkg::ADDR_FORMAT, 8'h1F);
		rd_reg(uart_irq_pkg::ADDR_FORMAT, 8'h1F);
		chk(fmt_q, 8'h1F);
		wr_reg(uart_irq_pkg::ADDR_TXDATA, 8'h5A);
		rd_reg(uart_irq_pkg::ADDR_STATUS, 8'h00);
		chk(txd_q, 8'h5A);
		ev(0, 8'h00, 1'b1);
		rd_reg(uart_irq_pkg::ADDR_STATUS, 8'h01);
		chk(pend, 1'b1);
		chk(acc, 1'b0);
		src <= 1;
		#6 chk(acc, 1'b1);
		$display("tx test done");
		b0 = $urandom; b1 = $urandom; b2 = $urandom;
		ev(1, b0, 1'b1);
		rd_reg(uart_irq_pkg::ADDR_STATUS, 8'h03);
		rd_reg(uart_irq_pkg::ADDR_RXDATA, b0);
		wr_reg(uart_irq_pkg::ADDR_CONTROL, 8'h72);
		ev(1, b1, 1'b0);
		ev(1, b2, 1'b1);
		ev(1, 8'hFF, 1'b1);
		rd_reg(uart_irq_pkg::ADDR_STATUS, 8'h1B);
		wr_reg(uart_irq_pkg::ADDR_STATUS, 8'h10);
		rd_reg(uart_irq_pkg::ADDR_STATUS, 8'h0B);
		rd_reg(uart_irq_pkg::ADDR_RXDATA, b1);
		rd_reg(uart_irq_pkg::ADDR_RXDATA, b2);
		ev(2, b0, 1'b1);
		ev(3, b1, 1'b1);
		rd_reg(uart_irq_pkg::ADDR_STATUS, 8'h6B);
		wr_reg(uart_irq_pkg::ADDR_STATUS, 8'h20);
		rd_reg(uart_irq_pkg::ADDR_STATUS, 8'h4B);
		rd_reg(uart_irq_pkg::ADDR_RXDATA, b0);
		rd_reg(uart_irq_pkg::ADDR_RXDATA, b1);
		wr_reg(uart_irq_pkg::ADDR_CONTROL, 8'h00);
		ev(2, b2, 1'b0);
		rd_reg(uart_irq_pkg::ADDR_RXDATA, b2);
		$display("rx test done");
		wr_reg(uart_irq_pkg::ADDR_EXPAND, 8'h71);
		rd_reg(uart_irq_pkg::ADDR_EXPAND, 8'h71);
		wr_reg(uart_irq_pkg::ADDR_EXPAND, 8'h01);
		@(posedge clk) rxp <= 0;
		repeat (2) @(posedge clk);
		rxp <= 1;
		repeat (80) @(posedge clk);
		chk(nrx, 0);
		rxp <= 0;
		repeat (6) @(posedge clk);
		rxp <= 1;
		repeat (100) @(posedge clk);
		chk(nrx >= 15 && nrx <= 17, 1'b1);
		txs <= 0;
		repeat (40) @(posedge clk);
		txs <= 1;
		repeat (20) @(posedge clk);
		chk(ntx >= 2 && ntx <= 4, 1'b1);
		wr_reg(uart_irq_pkg::ADDR_CONTROL, 8'h10);
		ev(0, 8'h00, 1'b1);
		$display("infrared test done");
		close_out();
	end
endmodule : tb
